// ### design/fprd_top.sv
// module: function line router, change detection, debounce and power-up states
`timescale 1ns/1ps
// Function
// [RULE1] sixteen function lines, indexed zero to fifteen, each general or timing terminal
// [RULE2] each line is static input, static output, timing input or timing output
// [RULE3] timing inputs route to every counter, sample clock and trigger destination
// [RULE4] routed inputs have selectable polarity and edge or level action
// [RULE5] output lines accept any exportable internal or backplane signal
// [RULE6] output sample clock is inverted, so it is active low on the pin
// [RULE7] level changes fire change detection; values are not captured as data
// [RULE8] enabled filter samples its input on each filter clock edge
// [RULE9] filtered level changes after N consecutive samples at the new level
// [RULE10] short uses 100 MHz with N of 9; medium 100 MHz with 512
// [RULE11] high uses 100 kHz filter clock with N of 256
// [RULE12] custom setting takes user N and user timebase
// [RULE13] every filterable input holds its own independent filter setting
// [RULE14] filters are disabled at power up, inputs pass unfiltered
// [RULE15] filter jitter never exceeds one filter timebase period
// [RULE16] trigger lines forwarded to a function line use the unfiltered version
// [RULE17] on reset every line becomes a high-impedance input with pull-down
// [RULE18] programmable power-up state: hi-z input, drive zero or drive one
// [RULE19] run counter restarts when sample equals filtered level; update at N
// [RULE20] pin inputs pass a two-stage synchroniser before filters or destinations
module fprd_top
    import fprd_pkg::*;
#(
    parameter int LINES = NUM_LINES                                   // [RULE1]
)
(
    input  wire logic                        clk,
    input  wire logic                        rstn,
    input  wire logic                        ce,
    // pins
    input  wire logic [LINES-1:0]            lineIn,
    output logic      [LINES-1:0]            lineOut,
    output logic      [LINES-1:0]            lineOe,
    output logic      [LINES-1:0]            linePullDown,
    // per line configuration
    input  wire fprd_pkg::fprd_mode_t        lineMode [LINES],
    input  wire logic [LINES-1:0]            staticOutVal,
    input  wire logic [fprd_pkg::SRC_SEL_W-1:0] exportSel [LINES],
    input  wire fprd_pkg::fprd_filt_t        filtSetting [LINES],
    input  wire logic [fprd_pkg::CNT_W-1:0]  customN [LINES],
    input  wire logic [fprd_pkg::CNT_W-1:0]  customDiv [LINES],
    input  wire fprd_pkg::fprd_pwrup_t       pwrUpState [LINES],
    input  wire logic                        pwrUpApply,
    input  wire logic [LINES-1:0]            changeDetEn,
    // internal signals offered for export, unfiltered trigger lines among them
    input  wire logic [fprd_pkg::NUM_SRC-1:0] exportSrc,
    // destination routing
    input  wire logic [3:0]                  destLineSel [fprd_pkg::NUM_DEST],
    input  wire logic [fprd_pkg::NUM_DEST-1:0] destInvert,
    input  wire logic [fprd_pkg::NUM_DEST-1:0] destEdge,
    // results
    output logic      [fprd_pkg::NUM_DEST-1:0] destOut,
    output logic      [LINES-1:0]            staticInVal,
    output logic                             changeEvent,
    output logic      [LINES-1:0]            filteredLine
);
    import fprd_pkg::*;

    function automatic logic [CNT_W-1:0] filtRunLen(input fprd_filt_t s,
                                                    input logic [CNT_W-1:0] cn);
        case (s)
            FPRD_FILT_SHORT:  filtRunLen = N_SHORT;                   // [RULE10]
            FPRD_FILT_MEDIUM: filtRunLen = N_MEDIUM;                  // [RULE10]
            FPRD_FILT_HIGH:   filtRunLen = N_HIGH;                    // [RULE11]
            FPRD_FILT_CUSTOM: filtRunLen = (cn == '0) ? CNT_W'(1) : cn; // [RULE12]
            default:          filtRunLen = CNT_W'(1);
        endcase
    endfunction

    function automatic logic isDriven(input fprd_mode_t m);
        isDriven = (m == FPRD_STATIC_OUT) || (m == FPRD_TIMING_OUT);
    endfunction

    logic [LINES-1:0] sync1_q;
    logic [LINES-1:0] sync2_q;
    logic [LINES-1:0] filt;
    logic [LINES-1:0] prevFilt_q;
    logic [CNT_W-1:0] slowCnt_q;
    logic             slowTick;
    logic             pwrUpDone_q;
    logic [NUM_DEST-1:0] destLvl_q;

    // two flops for asynchronous pins; only the second is read beyond this
    always_ff @(posedge clk)
    begin
        if (!rstn)
        begin
            sync1_q <= '0;
            sync2_q <= '0;
        end
        else if (ce)
        begin
            sync1_q <= lineIn;                                        // [RULE20]
            sync2_q <= sync1_q;                                       // [RULE20]
        end
    end

    // shared 100 kHz strobe for the high setting
    always_ff @(posedge clk)
    begin
        if (!rstn)
            slowCnt_q <= '0;
        else if (ce)
            slowCnt_q <= (slowCnt_q == CNT_W'(SLOW_DIV - 1)) ? '0 : slowCnt_q + 1'b1;
    end
    assign slowTick = (slowCnt_q == CNT_W'(SLOW_DIV - 1));

    // one filter per line, each with its own setting; only the custom setting has a per-line timebase
    generate
        for (genvar i = 0; i < LINES; i++)
        begin : gLine
            fprd_filt_if fif ();
            logic [CNT_W-1:0] custCnt_q;
            logic             custTick;

            always_ff @(posedge clk)
            begin
                if (!rstn)
                    custCnt_q <= '0;
                else if (ce)
                    custCnt_q <= (custCnt_q >= customDiv[i]) ? '0 : custCnt_q + 1'b1;
            end
            assign custTick = (custCnt_q >= customDiv[i]);           // [RULE12]

            assign fif.enable = (filtSetting[i] != FPRD_FILT_NONE);   // [RULE13]
            assign fif.runLen = filtRunLen(filtSetting[i], customN[i]);
            assign fif.tick   = (filtSetting[i] == FPRD_FILT_HIGH)   ? slowTick :
                                (filtSetting[i] == FPRD_FILT_CUSTOM) ? custTick :
                                1'b1;                                  // [RULE10]

            fprd_debounce uFilt (
                .clk     (clk),
                .rstn    (rstn),
                .ce      (ce),
                .cfg     (fif.filt),
                .rawIn   (sync2_q[i]),
                .filtOut (filt[i])
            );
        end
    endgenerate

    // power-up state applies once after reset, or again on request
    always_ff @(posedge clk)
    begin
        if (!rstn)
            pwrUpDone_q <= 1'b0;
        else if (ce)
            pwrUpDone_q <= 1'b1;
    end

    // pin drivers: reset leaves every line undriven with its pull-down
    always_ff @(posedge clk)
    begin
        if (!rstn)
        begin
            lineOe       <= '0;                                       // [RULE17]
            lineOut      <= '0;
            linePullDown <= {LINES{1'b1}};                            // [RULE17]
        end
        else if (ce)
        begin
            for (int i = 0; i < LINES; i++)
            begin
                if (!pwrUpDone_q || pwrUpApply)
                begin
                    lineOe[i]       <= (pwrUpState[i] != FPRD_PU_HIZ); // [RULE18]
                    lineOut[i]      <= (pwrUpState[i] == FPRD_PU_DRIVE1);
                    linePullDown[i] <= (pwrUpState[i] == FPRD_PU_HIZ);
                end
                else
                begin
                    lineOe[i]       <= isDriven(lineMode[i]);         // [RULE2]
                    linePullDown[i] <= !isDriven(lineMode[i]);
                    if (lineMode[i] == FPRD_STATIC_OUT)
                        lineOut[i] <= staticOutVal[i];
                    else if (exportSel[i] == SRC_DO_SAMPLE_CLK)
                        lineOut[i] <= !exportSrc[exportSel[i]];       // [RULE6]
                    else
                        lineOut[i] <= exportSrc[exportSel[i]];        // [RULE5] [RULE16]
                end
            end
        end
    end

    // static input readback and change detection on filtered levels
    always_ff @(posedge clk)
    begin
        if (!rstn)
        begin
            staticInVal  <= '0;
            filteredLine <= '0;
            prevFilt_q   <= '0;
            changeEvent  <= 1'b0;
        end
        else if (ce)
        begin
            staticInVal  <= filt;
            filteredLine <= filt;
            prevFilt_q   <= filt;
            // fires only; line values are never latched as timed data
            changeEvent  <= |((filt ^ prevFilt_q) & changeDetEn);     // [RULE7]
        end
    end

    // destination routing with polarity and edge or level action
    always_ff @(posedge clk)
    begin
        if (!rstn)
        begin
            destLvl_q <= '0;
            destOut   <= '0;
        end
        else if (ce)
        begin
            for (int d = 0; d < NUM_DEST; d++)
            begin
                logic lvl;
                lvl          = filt[destLineSel[d]] ^ destInvert[d];  // [RULE4]
                destLvl_q[d] <= lvl;
                if (lineMode[destLineSel[d]] != FPRD_TIMING_IN)
                    destOut[d] <= 1'b0;
                else if (destEdge[d])
                    destOut[d] <= lvl && !destLvl_q[d];               // [RULE3]
                else
                    destOut[d] <= lvl;                                // [RULE3]
            end
        end
    end

    AST_RESET_HIZ: assert property (@(posedge clk)
        !rstn |=> (lineOe == '0) && (linePullDown == {LINES{1'b1}})) // [RULE17]
        else $error("lines not high impedance after reset");
    AST_SYNC_TWO: assert property (@(posedge clk) disable iff (!rstn)
        (ce && $past(ce) && $past(ce, 2) && $past(rstn) && $past(rstn, 2))
        |-> sync2_q == $past(lineIn, 2))                              // [RULE20]
        else $error("synchroniser depth is not two");
    AST_PWRUP_DRIVE: assert property (@(posedge clk) disable iff (!rstn)
        (ce && !pwrUpDone_q && pwrUpState[0] == FPRD_PU_DRIVE1)
        |=> lineOe[0] && lineOut[0])                                  // [RULE18]
        else $error("power-up drive one not applied");
    AST_CHANGE_EVT: assert property (@(posedge clk) disable iff (!rstn)
        (ce && changeDetEn[0] && filt[0] != prevFilt_q[0]) |=> changeEvent) // [RULE7]
        else $error("change on enabled line gave no event");
    AST_DO_CLK_INV: assert property (@(posedge clk) disable iff (!rstn)
        (ce && pwrUpDone_q && !pwrUpApply && lineMode[0] == FPRD_TIMING_OUT
         && exportSel[0] == SRC_DO_SAMPLE_CLK)
        |=> lineOut[0] == !$past(exportSrc[SRC_DO_SAMPLE_CLK]))      // [RULE6]
        else $error("output sample clock not inverted on pin");
    AST_UNFILT_PASS: assert property (@(posedge clk) disable iff (!rstn)
        (filtSetting[0] == FPRD_FILT_NONE) |-> filt[0] == sync2_q[0]) // [RULE14]
        else $error("disabled filter altered the line");
endmodule

// ### design/fprd_pkg.sv
// package: constants and types for the function line router and debounce block
package fprd_pkg;
    localparam int NUM_LINES     = 16;
    localparam int NUM_SRC       = 32;
    localparam int SRC_SEL_W     = 5;
    localparam int NUM_DEST      = 32;
    localparam int DEST_SEL_W    = 5;
    localparam int CNT_W         = 16;

    // filter settings
    localparam int CLK_HZ        = 100_000_000;
    localparam int FAST_FILT_HZ  = 100_000_000;
    localparam int SLOW_FILT_HZ  = 100_000;
    localparam int SLOW_DIV      = CLK_HZ / SLOW_FILT_HZ;
    localparam int FAST_DIV      = CLK_HZ / FAST_FILT_HZ;
    localparam logic [CNT_W-1:0] N_SHORT  = 16'h0009;
    localparam logic [CNT_W-1:0] N_MEDIUM = 16'h0200;
    localparam logic [CNT_W-1:0] N_HIGH   = 16'h0100;

    // export source index whose level is inverted on the pin
    localparam logic [SRC_SEL_W-1:0] SRC_DO_SAMPLE_CLK = 5'h04;

    typedef enum logic [1:0] {
        FPRD_STATIC_IN,
        FPRD_STATIC_OUT,
        FPRD_TIMING_IN,
        FPRD_TIMING_OUT
    } fprd_mode_t;

    typedef enum logic [2:0] {
        FPRD_FILT_NONE,
        FPRD_FILT_SHORT,
        FPRD_FILT_MEDIUM,
        FPRD_FILT_HIGH,
        FPRD_FILT_CUSTOM
    } fprd_filt_t;

    typedef enum logic [1:0] {
        FPRD_PU_HIZ,
        FPRD_PU_DRIVE0,
        FPRD_PU_DRIVE1
    } fprd_pwrup_t;
endpackage

// ### design/fprd_filt_if.sv
// interface: filter setting and timebase strobes passed to a debounce filter
`timescale 1ns/1ps
interface fprd_filt_if;
    import fprd_pkg::*;
    logic             enable;
    logic             tick;
    logic [CNT_W-1:0] runLen;
    modport ctrl (output enable, output tick, output runLen);
    modport filt (input enable, input tick, input runLen);
endinterface

// ### design/fprd_debounce.sv
// module: one debouncing filter with run counter
`timescale 1ns/1ps
module fprd_debounce
    import fprd_pkg::*;
(
    input  wire logic  clk,
    input  wire logic  rstn,
    input  wire logic  ce,
    fprd_filt_if.filt  cfg,
    input  wire logic  rawIn,
    output logic       filtOut
);
    logic [CNT_W-1:0] run_q;
    logic             level_q;

    // counts consecutive ticks that disagree with the held level
    always_ff @(posedge clk)
    begin
        if (!rstn)
        begin
            run_q   <= '0;
            level_q <= 1'b0;
        end
        else if (ce && cfg.enable && cfg.tick)                       // [RULE8]
        begin
            if (rawIn == level_q)
                run_q <= '0;                                          // [RULE19]
            else if (run_q + 1'b1 >= cfg.runLen)
            begin
                level_q <= rawIn;                                     // [RULE9] [RULE15]
                run_q   <= '0;
            end
            else
                run_q <= run_q + 1'b1;
        end
        else if (ce && !cfg.enable)
        begin
            level_q <= rawIn;
            run_q   <= '0;
        end
    end

    // disabled filter passes the synchronised input straight on
    assign filtOut = cfg.enable ? level_q : rawIn;                    // [RULE14]

    AST_FILT_HOLD: assert property (@(posedge clk) disable iff (!rstn)
        (ce && cfg.enable && !cfg.tick && $past(cfg.enable)) |=> $stable(level_q)) // [RULE9]
        else $error("filtered level moved without a filter tick");
    AST_FILT_RESTART: assert property (@(posedge clk) disable iff (!rstn)
        (ce && cfg.enable && cfg.tick && rawIn == level_q) |=> run_q == '0) // [RULE19]
        else $error("run counter did not restart on agreeing sample");
endmodule

// ### verif/fprd_line_model.sv
// model: external sources and loads seen on the function line pins
`timescale 1ns/1ps
module fprd_line_model
(
    input  wire logic        clk,
    input  wire logic [15:0] lineOut,
    input  wire logic [15:0] lineOe,
    input  wire logic [15:0] linePullDown,
    output logic      [15:0] pinLevel
);
    logic [15:0] extVal;
    logic [15:0] extEn;
    logic [15:0] floatVal;

    initial
    begin
        extVal = 16'h0000;
        extEn = 16'h0000;
        floatVal = 16'h5555;
    end

    // a floating line without pull-down toggles, so a stale level never reads as data
    always @(posedge clk)
        floatVal <= ~floatVal;

    always_comb
        for (int i = 0; i < 16; i++)
            pinLevel[i] = lineOe[i] ? lineOut[i] : extEn[i] ? extVal[i] :
                linePullDown[i] ? 1'b0 : floatVal[i];

    task automatic drive(input int ln, input logic v);
        @(posedge clk);
        extEn[ln] <= 1'b1;
        extVal[ln] <= v;
    endtask

    task automatic pulse(input int ln, input int width);
        drive(ln, 1'b1);
        repeat (width - 1) @(posedge clk);
        drive(ln, 1'b0);
    endtask
endmodule

// ### verif/fprd_tb_top.sv
// testbench: pin modes, routing, change events, debounce and power-up states
`timescale 1ns/1ps
module fprd_tb_top;
    import fprd_pkg::*;
    typedef struct {int ln; fprd_mode_t md; logic sv; logic [4:0] sel;
        logic [31:0] src; logic eOut; logic eOe;} fprd_row_t;
    logic                  clk, rstn, ce, pwrUpApply, changeEvent;
    logic [15:0]           lineIn, lineOut, lineOe, linePullDown, staticOutVal;
    logic [15:0]           changeDetEn, staticInVal, filteredLine;
    logic [31:0]           exportSrc, destInvert, destEdge, destOut;
    fprd_mode_t            lineMode [16];
    logic [SRC_SEL_W-1:0]  exportSel [16];
    fprd_filt_t            filtSetting [16];
    logic [CNT_W-1:0]      customN [16], customDiv [16];
    fprd_pwrup_t           pwrUpState [16];
    logic [3:0]            destLineSel [32];
    int                    nErrors = 0, nCompared = 0;
    fprd_row_t rows [6] = '{
        '{0, FPRD_STATIC_OUT, 1'b1, 5'h00, 32'h0000_0000, 1'b1, 1'b1},
        '{1, FPRD_STATIC_OUT, 1'b0, 5'h00, 32'hffff_ffff, 1'b0, 1'b1},
        '{2, FPRD_TIMING_OUT, 1'b0, 5'h03, 32'h0000_0008, 1'b1, 1'b1},
        '{3, FPRD_TIMING_OUT, 1'b0, 5'h04, 32'h0000_0010, 1'b0, 1'b1},
        '{0, FPRD_TIMING_OUT, 1'b0, 5'h04, 32'h0000_0000, 1'b1, 1'b1},
        '{15, FPRD_STATIC_IN, 1'b1, 5'h00, 32'h0000_0000, 1'b0, 1'b0}};
    // line, setting, run length, timebase divider
    int fr [4][4] = '{'{7, 1, 9, 0}, '{8, 4, 5, 0}, '{9, 4, 3, 1}, '{10, 2, 512, 0}};

    fprd_top dut (.clk, .rstn, .ce, .lineIn, .lineOut, .lineOe, .linePullDown, .lineMode,
        .staticOutVal, .exportSel, .filtSetting, .customN, .customDiv, .pwrUpState,
        .pwrUpApply, .changeDetEn, .exportSrc, .destLineSel, .destInvert, .destEdge,
        .destOut, .staticInVal, .changeEvent, .filteredLine);
    fprd_line_model model (.clk, .lineOut, .lineOe, .linePullDown, .pinLevel(lineIn));

    task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
        nCompared++;
        if (seen !== exp)
        begin
            $display("ERROR %s expected %h seen %h", what, exp, seen);
            nErrors++;
        end
    endtask

    task automatic printVerdict();
        $display("compared %0d mismatches %0d", nCompared, nErrors);
        if (nErrors == 0 && nCompared > 0)
            $display("verification passed");
        else
            $display("verification failed");
        $finish;
    endtask

    task automatic lat(input int ln, input logic v, output int n);
        n = 0;
        while (filteredLine[ln] !== v && n < 40)
        begin
            @(posedge clk);
            #1;
            n++;
        end
    endtask

    task automatic watch(input int ln, input int span, output logic hit);
        hit = 1'b0;
        repeat (span)
        begin
            @(posedge clk);
            #1;
            if (filteredLine[ln] === 1'b1)
                hit = 1'b1;
        end
    endtask

    initial
    begin
        clk = 1'b0;
        forever #5 clk = ~clk;
    end

    // filters are short except one 512-sample run, so this span is generous
    initial
    begin
        repeat (20000) @(posedge clk);
        nErrors++;
        printVerdict();
    end

    initial
    begin
        int n;
        int ln;
        int w;
        logic hit;
        rstn = 1'b0;
        ce = 1'b1;
        pwrUpApply = 1'b0;
        staticOutVal = 16'h0000;
        changeDetEn = 16'h0000;
        exportSrc = 32'h0000_0000;
        destInvert = 32'h0000_0000;
        destEdge = 32'h0000_0000;
        for (int i = 0; i < 16; i++)
        begin
            lineMode[i] = FPRD_STATIC_IN;
            exportSel[i] = 5'h00;
            filtSetting[i] = FPRD_FILT_NONE;
            customN[i] = 16'h0001;
            customDiv[i] = 16'h0000;
            pwrUpState[i] = FPRD_PU_HIZ;
        end
        for (int d = 0; d < 32; d++)
            destLineSel[d] = 4'h5;
        repeat (10) @(posedge clk);
        #1;
        check("lineOe", lineOe, 16'h0000);
        check("linePullDown", linePullDown, 16'hffff);
        @(posedge clk);
        rstn <= 1'b1;
        foreach (rows[r])
        begin
            @(posedge clk);
            lineMode[rows[r].ln] <= rows[r].md;
            staticOutVal[rows[r].ln] <= rows[r].sv;
            exportSel[rows[r].ln] <= rows[r].sel;
            exportSrc <= rows[r].src;
            if (rows[r].md == FPRD_STATIC_IN)
                model.drive(rows[r].ln, rows[r].sv);
            repeat (5) @(posedge clk);
            #1;
            check("lineOe", lineOe[rows[r].ln], rows[r].eOe);
            if (rows[r].eOe)
                check("lineOut", lineOut[rows[r].ln], rows[r].eOut);
            else
                check("staticInVal", staticInVal[rows[r].ln], rows[r].sv);
        end
        $display("pin mode rows done");
        @(posedge clk);
        lineMode[5] <= FPRD_TIMING_IN;
        changeDetEn[5] <= 1'b1;
        destInvert <= 32'haaaa_aaaa;
        repeat (5) @(posedge clk);
        model.drive(5, 1'b1);
        lat(5, 1'b1, n);
        check("unfiltered latency", n, 3);
        check("destOut level", destOut, 32'h5555_5555);
        check("changeEvent", changeEvent, 1'b1);
        @(posedge clk);
        #1;
        check("changeEvent end", changeEvent, 1'b0);
        @(posedge clk);
        destEdge <= 32'h0000_0001;
        destInvert <= 32'h0000_0000;
        destLineSel[31] <= 4'h6;
        model.drive(5, 1'b0);
        model.drive(6, 1'b1);
        repeat (6) @(posedge clk);
        #1;
        check("refused line", destOut[31], 1'b0);
        model.drive(5, 1'b1);
        n = 0;
        repeat (8)
        begin
            @(posedge clk);
            #1;
            n += destOut[0];
        end
        check("edge pulses", n, 1);
        $display("routing test done");
        foreach (fr[r])
        begin
            ln = fr[r][0];
            w = fr[r][2] * (fr[r][3] + 1);
            @(posedge clk);
            lineMode[ln] <= FPRD_TIMING_IN;
            filtSetting[ln] <= fprd_filt_t'(fr[r][1]);
            customN[ln] <= 16'(fr[r][2]);
            customDiv[ln] <= 16'(fr[r][3]);
            repeat (4) @(posedge clk);
            fork
                model.pulse(ln, w - fr[r][3] - 1);
                watch(ln, 2 * w + 20, hit);
            join
            check("pulse blocked", hit, 1'b0);
            fork
                model.pulse(ln, w);
                watch(ln, 2 * w + 20, hit);
            join
            check("pulse passed", hit, 1'b1);
        end
        $display("filter test done");
        @(posedge clk);
        pwrUpState[0] <= FPRD_PU_DRIVE1;
        pwrUpState[11] <= FPRD_PU_DRIVE1;
        pwrUpState[12] <= FPRD_PU_DRIVE0;
        pwrUpApply <= 1'b1;
        rstn <= 1'b0;
        repeat (3) @(posedge clk);
        #1;
        check("lineOe in reset", lineOe, 16'h0000);
        check("filtered in reset", filteredLine, 16'h0000);
        @(posedge clk);
        rstn <= 1'b1;
        repeat (3) @(posedge clk);
        #1;
        check("power-up oe", lineOe[13:11], 3'b011);
        check("power-up out", lineOut[12:11], 2'b01);
        $display("power-up test done");
        printVerdict();
    end
endmodule
